/* hdl/tdo_seq.sv */
// tone digit output sequencer: code, strobe, pause and clear timing
// Contract
// [R1] code valid within 40 ms of a tone pair starting
// [R2] strobe rises seven microseconds after code becomes valid
// [R3] strobe and code held steady while the tone pair lasts
// [R4] valid pause recognised within 40 ms after tone ends
// [R5] strobe drops about 45 ms after tone ends
// [R6] code forced to zero 4.56 ms after strobe falls
// [R7] strobe lasts at least as long as the tone pair
// [R8] code outputs are three-state for bus sharing
// [R9] all timing derived from one 3.58 MHz oscillator-rate enable; the enable here runs at 125 MHz / 34, about 3.68 MHz
// [R10] handshake: monitor polls, captures, pulses clear; strobe then drops
// [R11] all-zero code marks cleared outputs, hence a valid pause
// [R12] code driven only while output enable is high
`timescale 1ns/1ns
module tdo_seq
  import tdo_pkg::*;
#(
  parameter int unsigned OSC_DIV = TDO_OSC_DIV,
  parameter int unsigned DETECT_TICKS = TDO_DETECT_TICKS,
  parameter int unsigned SETUP_TICKS = TDO_SETUP_TICKS,
  parameter int unsigned PAUSE_TICKS = TDO_PAUSE_TICKS,
  // counted from the end of the tone, so it must exceed the pause count
  parameter int unsigned RELEASE_TICKS = TDO_RELEASE_TICKS,
  parameter int unsigned HOLD_TICKS = TDO_HOLD_TICKS
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic tone_present,
  input wire logic [3:0] tone_code,
  input wire logic strobe_clear,
  input wire logic out_enable,
  output tdo_pins_s code_pins,
  output logic digit_valid_strobe,
  output logic pause_seen
);
  ////////////////////////////////////////////////////////////////////////////////
  logic tick;
  tdo_state_e st_r;
  tdo_state_e st_nxt;
  logic [TDO_TW-1:0] tmr_r;
  logic [TDO_TW-1:0] tmr_nxt;
  tdo_code_s code_r;
  tdo_code_s code_nxt;
  logic dv_r;
  logic dv_nxt;
  logic pause_r;
  logic pause_nxt;

  // one shared enable keeps every interval locked to the oscillator rate
  tdo_tick_div #(
    .DIV(OSC_DIV)
  ) i_tdo_tick_div (
    .clock(clock),
    .srst(srst),
    .tick(tick)
  ); // [R9]

  function automatic logic [TDO_TW-1:0] tinc(input logic [TDO_TW-1:0] v);
    tinc = (v == {TDO_TW{1'b1}}) ? v : v + TDO_T_ONE;
  endfunction

  function automatic logic reached(input logic [TDO_TW-1:0] v, input int unsigned lim);
    reached = (v >= TDO_TW'(lim));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    code_nxt = code_r;
    dv_nxt = dv_r;
    pause_nxt = pause_r;
    // handshake clear drops the strobe but leaves the code; a strobe being
    // raised in the same cycle overrides it so a fresh digit is never lost
    if (strobe_clear)
      dv_nxt = 1'b0; // [R10]
    case (st_r)
      TDO_IDLE:
      begin
        if (!tone_present)
          tmr_nxt = TDO_T_ZERO;
        else if (tick)
        begin
          tmr_nxt = tinc(tmr_r);
          // a tone must persist for the detect time before the code latches
          if (reached(tmr_r, DETECT_TICKS - 1))
          begin
            code_nxt = tdo_code_s'(tone_code); // [R1]
            pause_nxt = 1'b0;
            tmr_nxt = TDO_T_ZERO;
            st_nxt = TDO_SETUP;
          end
        end
      end
      TDO_SETUP:
      begin
        if (tick)
        begin
          tmr_nxt = tinc(tmr_r);
          if (reached(tmr_r, SETUP_TICKS - 1))
          begin
            dv_nxt = 1'b1; // [R2]
            tmr_nxt = TDO_T_ZERO;
            st_nxt = TDO_VALID;
          end
        end
      end
      TDO_VALID:
      begin
        // code is frozen here; tone_code changes are ignored until the next detect in idle
        if (!tone_present && tick)
        begin
          tmr_nxt = tinc(tmr_r);
          // the timer runs on into release, so release is timed from tone end
          if (reached(tmr_r, PAUSE_TICKS - 1))
          begin
            pause_nxt = 1'b1; // [R4]
            st_nxt = TDO_RELEASE;
          end
        end
        else if (tone_present)
          tmr_nxt = TDO_T_ZERO; // [R3] [R7]
      end
      TDO_RELEASE:
      begin
        if (tone_present)
        begin
          // a fresh tone before the release aborts the pause
          tmr_nxt = TDO_T_ZERO;
          pause_nxt = 1'b0;
          st_nxt = TDO_VALID;
        end
        else if (tick)
        begin
          tmr_nxt = tinc(tmr_r);
          if (reached(tmr_r, RELEASE_TICKS - 1))
          begin
            dv_nxt = 1'b0; // [R5]
            tmr_nxt = TDO_T_ZERO;
            st_nxt = TDO_HOLD;
          end
        end
      end
      TDO_HOLD:
      begin
        if (tick)
        begin
          tmr_nxt = tinc(tmr_r);
          if (reached(tmr_r, HOLD_TICKS - 1))
          begin
            code_nxt = tdo_code_s'(TDO_CODE_CLEAR); // [R6] [R11]
            tmr_nxt = TDO_T_ZERO;
            st_nxt = TDO_IDLE;
          end
        end
      end
      default:
      begin
        st_nxt = TDO_IDLE;
        tmr_nxt = TDO_T_ZERO;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      st_r <= TDO_IDLE;
      tmr_r <= TDO_T_ZERO;
      code_r <= tdo_code_s'(TDO_CODE_CLEAR);
      dv_r <= 1'b0;
      pause_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      code_r <= code_nxt;
      dv_r <= dv_nxt;
      pause_r <= pause_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign code_pins = '{o: code_r, oe: {4{out_enable}}}; // [R8] [R12]
  assign digit_valid_strobe = dv_r;
  assign pause_seen = pause_r;
endmodule

/* hdl/tdo_pkg.sv */
// shared constants and carrier types for the tone digit output sequencer
package tdo_pkg;
  localparam int unsigned TDO_CLK_HZ = 125000000;
  localparam int unsigned TDO_OSC_HZ = 3580000;
  // divider from the system clock to the oscillator rate
  localparam int unsigned TDO_OSC_DIV = TDO_CLK_HZ / TDO_OSC_HZ;
  localparam int unsigned TDO_OSC_HZ_REAL = TDO_CLK_HZ / TDO_OSC_DIV;
  // times in their own units
  localparam int unsigned TDO_DETECT_MS = 40;
  localparam int unsigned TDO_SETUP_US = 7;
  localparam int unsigned TDO_PAUSE_MS = 40;
  localparam int unsigned TDO_RELEASE_MS = 45;
  localparam int unsigned TDO_HOLD_US = 4560;
  // counts of oscillator ticks: least times round up, longest round down
  localparam int unsigned TDO_SETUP_TICKS = (TDO_SETUP_US * (TDO_OSC_HZ_REAL / 1000) + 999) / 1000;
  localparam int unsigned TDO_DETECT_TICKS = TDO_DETECT_MS * (TDO_OSC_HZ_REAL / 1000);
  localparam int unsigned TDO_PAUSE_TICKS = TDO_PAUSE_MS * (TDO_OSC_HZ_REAL / 1000);
  localparam int unsigned TDO_RELEASE_TICKS = TDO_RELEASE_MS * (TDO_OSC_HZ_REAL / 1000);
  localparam int unsigned TDO_HOLD_TICKS = TDO_HOLD_US * (TDO_OSC_HZ_REAL / 1000) / 1000;
  localparam int unsigned TDO_TW = 20;
  localparam logic [3:0] TDO_CODE_CLEAR = 4'h0;
  localparam logic [TDO_TW-1:0] TDO_T_ZERO = 20'h00000;
  localparam logic [TDO_TW-1:0] TDO_T_ONE = 20'h00001;

  typedef enum logic [2:0] {
    TDO_IDLE = 3'b000,
    TDO_SETUP = 3'b001,
    TDO_VALID = 3'b011,
    TDO_RELEASE = 3'b010,
    TDO_HOLD = 3'b110
  } tdo_state_e;

  // code lines: the four weighted bits; their enable lines sit in tdo_pins_s
  typedef struct packed {
    logic code_bit_weight_eight;
    logic code_bit_weight_four;
    logic code_bit_weight_two;
    logic code_bit_weight_one;
  } tdo_code_s;

  typedef struct packed {
    tdo_code_s o;
    logic [3:0] oe;
  } tdo_pins_s;
endpackage

/* hdl/tdo_tick_div.sv */
// oscillator-rate enable divider
`timescale 1ns/1ns
module tdo_tick_div
  import tdo_pkg::*;
#(
  parameter int unsigned DIV = TDO_OSC_DIV
)
(
  input wire logic clock,
  input wire logic srst,
  output logic tick
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic tick_nxt;
  logic tick_r;

  always_comb
  begin
    tick_nxt = 1'b0;
    cnt_nxt = cnt_r + 8'h01;
    if (cnt_r == 8'(DIV - 1))
    begin
      cnt_nxt = 8'h00;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule

/* verification/tdo_seq_checker.sv */
// port assertions for the tone digit output sequencer
`timescale 1ns/1ns
module tdo_seq_checker
  import tdo_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic tone_present,
  input wire logic [3:0] tone_code,
  input wire logic strobe_clear,
  input wire logic out_enable,
  input wire tdo_pins_s code_pins,
  input wire logic digit_valid_strobe,
  input wire logic pause_seen
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  a_oe_follows: assert property (code_pins.oe == {4{out_enable}})
    else $error("enable lines off");
  a_clear_drops: assert property (strobe_clear |=> !digit_valid_strobe || $rose(digit_valid_strobe))
    else $error("strobe kept after clear");
  a_tone_keeps: assert property (tone_present && digit_valid_strobe && !strobe_clear |=> digit_valid_strobe)
    else $error("strobe lost in tone");
  a_code_steady: assert property (digit_valid_strobe && $past(digit_valid_strobe) |-> $stable(code_pins.o))
    else $error("code moved");
  a_setup_first: assert property ($rose(digit_valid_strobe) |-> $past(code_pins.o, 8) == code_pins.o)
    else $error("code not settled");
  a_pause_low: assert property ($rose(pause_seen) |-> !$past(tone_present))
    else $error("pause in tone");
  a_fall_cause: assert property ($fell(digit_valid_strobe) |-> $past(strobe_clear) || !$past(tone_present))
    else $error("strobe fell in tone");
  a_zero_after: assert property ($fell(|code_pins.o) |-> !digit_valid_strobe)
    else $error("code cleared early");
  a_clear_pause: assert property ($fell(|code_pins.o) |-> pause_seen)
    else $error("code cleared without pause");
  c_pause: cover property ($rose(pause_seen));
  c_clear: cover property (strobe_clear);
  c_tone: cover property ($rose(tone_present));
  c_float: cover property ($fell(out_enable));
endmodule
bind tdo_seq tdo_seq_checker i_tdo_seq_checker (.clock(clock), .srst(srst), .tone_present(tone_present),
  .tone_code(tone_code), .strobe_clear(strobe_clear), .out_enable(out_enable), .code_pins(code_pins),
  .digit_valid_strobe(digit_valid_strobe), .pause_seen(pause_seen));

/* verification/tdo_monitor.sv */
// monitoring side: polls the strobe, captures the code, pulses the clear
`timescale 1ns/1ns
module tdo_monitor
  import tdo_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic enable,
  input wire logic digit_valid_strobe,
  input wire logic [3:0] bus_code,
  output logic strobe_clear,
  output logic [3:0] captured
);
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      strobe_clear <= 1'b0;
      captured <= 4'h0;
    end
    else
    begin
      // polls every cycle, far inside the 40 ms bound
      strobe_clear <= enable && digit_valid_strobe && !strobe_clear;
      if (enable && digit_valid_strobe && !strobe_clear)
        captured <= bus_code;
    end
  end
endmodule

/* verification/tdo_seq_tb_top.sv */
// self-checking bench for the tone digit output sequencer
`timescale 1ns/1ns
module tdo_seq_tb_top;
  import tdo_pkg::*;
  // short counts keep a whole digit inside a few hundred cycles
  localparam int unsigned B_DIV = 2;
  localparam int unsigned B_DETECT = 16;
  localparam int unsigned B_SETUP = 5;
  localparam int unsigned B_PAUSE = 16;
  localparam int unsigned B_RELEASE = 24;
  localparam int unsigned B_HOLD = 5;
  localparam int unsigned WAIT_MAX = 200;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic tone_present = 1'b0;
  logic [3:0] tone_code = 4'h0;
  logic out_enable = 1'b0;
  logic mon_enable = 1'b0;
  logic strobe_clear;
  logic digit_valid_strobe;
  logic pause_seen;
  logic [3:0] captured;
  logic [3:0] bus_code;
  tdo_pins_s code_pins;
  int bad_count = 0;
  int n_compared = 0;
  logic hung = 1'b0;
  // rows: out_enable, tone, code; cycles to wait -> oe lines, code, strobe, pause
  // one digit: detect, setup, code frozen while floated, pause, release, clear
  logic [5:0] stim [8] = '{6'h35, 6'h35, 6'h35, 6'h1A, 6'h2A, 6'h2A, 6'h2A, 6'h2A};
  logic [7:0] wait_cyc [8] = '{8'h14, 8'h10, 8'h14, 8'h0A, 8'h14, 8'h14, 8'h0C, 8'h0A};
  logic [9:0] want [8] = '{10'h3C0, 10'h3D4, 10'h3D6, 10'h016, 10'h3D6, 10'h3D7, 10'h3D5, 10'h3C1};
  // a released bus shows the inverse of the last code, so a floating capture is caught
  assign bus_code = (code_pins.oe == 4'hF) ? code_pins.o : ~code_pins.o;
  tdo_seq #(.OSC_DIV(B_DIV), .DETECT_TICKS(B_DETECT), .SETUP_TICKS(B_SETUP), .PAUSE_TICKS(B_PAUSE),
    .RELEASE_TICKS(B_RELEASE), .HOLD_TICKS(B_HOLD))
    i_tdo_seq (.clock(clock), .srst(srst), .tone_present(tone_present), .tone_code(tone_code),
    .strobe_clear(strobe_clear), .out_enable(out_enable), .code_pins(code_pins),
    .digit_valid_strobe(digit_valid_strobe), .pause_seen(pause_seen));
  tdo_monitor i_tdo_monitor (.clock(clock), .srst(srst), .enable(mon_enable),
    .digit_valid_strobe(digit_valid_strobe), .bus_code(bus_code), .strobe_clear(strobe_clear),
    .captured(captured));
  initial
  begin
    forever #4 clock = ~clock;
  end
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [9:0] seen_now;
    return {code_pins.oe, code_pins.o, digit_valid_strobe, pause_seen};
  endfunction
  initial
  begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    #1;
    chk(seen_now(), 10'h000);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock);
      {out_enable, tone_present, tone_code} <= stim[i];
      repeat (wait_cyc[i]) @(posedge clock);
      #1;
      chk(seen_now(), want[i]);
    end
    // handshake: the monitor takes the code and clears the strobe at once
    @(posedge clock);
    mon_enable <= 1'b1;
    {out_enable, tone_present, tone_code} <= 6'h39;
    for (int k = 0; k < WAIT_MAX && !strobe_clear; k++)
    begin
      @(posedge clock);
      #1;
    end
    if (!strobe_clear)
      hung = 1'b1;
    chk({9'h000, strobe_clear}, 10'h001);
    if (!hung)
    begin
      repeat (2) @(posedge clock);
      #1;
      chk({6'h00, captured}, 10'h009);
      chk(seen_now(), 10'h3E4);
      // with the strobe already cleared the strobe cannot mark the pause; the zeroed code and pause_seen reveal it
      @(posedge clock);
      tone_present <= 1'b0;
      for (int k = 0; k < WAIT_MAX && (|code_pins.o); k++)
      begin
        @(posedge clock);
        #1;
      end
      if (|code_pins.o)
        hung = 1'b1;
      chk(seen_now(), 10'h3C1);
    end
    // reset in mid-digit must clear the count as well as the outputs
    if (!hung)
    begin
      @(posedge clock);
      mon_enable <= 1'b0;
      {out_enable, tone_present, tone_code} <= 6'h33;
      for (int k = 0; k < WAIT_MAX && !digit_valid_strobe; k++)
      begin
        @(posedge clock);
        #1;
      end
      chk({9'h000, digit_valid_strobe}, 10'h001);
      @(posedge clock);
      srst <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk(seen_now(), 10'h3C0);
      @(posedge clock);
      srst <= 1'b0;
      repeat (20) @(posedge clock);
      #1;
      chk(seen_now(), 10'h3C0);
      repeat (20) @(posedge clock);
      #1;
      chk(seen_now(), 10'h3CC);
      chk({9'h000, strobe_clear}, 10'h000);
    end
    test_done();
  end
endmodule
